/* File: hw/bfps_pkg.sv */
// Constants, types and carriers for the buck fault-protection sequencer.
// Assumes a 20 MHz logic clock and a 400 kHz switching period.
package bfps_pkg;
	// ****************************************************************
	// Clock and switching period
	// ****************************************************************
	localparam int CLK_HZ = 20_000_000; // Logic clock rate
	localparam int CLK_NS = 50; // Logic clock period
	localparam int SW_HZ = 400_000; // Switching rate
	localparam int PER_CYC = CLK_HZ / SW_HZ; // Clocks per switching cycle
	localparam int DUTY_PCT = 80; // Maximum duty cycle
	localparam int DUTY_CYC = PER_CYC * DUTY_PCT / 100;
	localparam int DEAD_CYC = 2; // Dead time between drives
	localparam int BLANK_CYC = 2; // Settling after dead time before sensing
	localparam logic [5:0] PER_LAST = 6'(PER_CYC - 1);
	localparam logic [5:0] DUTY_MAX = 6'(DUTY_CYC);
	localparam logic [5:0] DEAD_T = 6'(DEAD_CYC);
	localparam logic [5:0] LS_END = 6'(PER_CYC - DEAD_CYC);
	localparam logic [5:0] OC_SAMP_OFS = 6'(DEAD_CYC + BLANK_CYC);
	// ****************************************************************
	// Protection limits
	// ****************************************************************
	localparam int OC_RUN = 4; // Consecutive events to shut down
	localparam int HIC_MAX = 3; // Overcurrent restarts before latch-off
	localparam logic [2:0] OC_LAST = 3'(OC_RUN - 1);
	localparam logic [1:0] HIC_LAST = 2'(HIC_MAX);
	localparam int UV_NS = 10_000; // Undervoltage detection delay
	localparam int UV_CYC = (UV_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [7:0] UV_LAST = 8'(UV_CYC - 1);
	// ****************************************************************
	// Start-up timing
	// ****************************************************************
	localparam int DET_HZ = 6000; // Detection pulse rate
	localparam int DET_CYC = CLK_HZ / DET_HZ;
	localparam int DET_W_NS = 1000; // Detection pulse width
	localparam int DET_W_CYC = (DET_W_NS + CLK_NS - 1) / CLK_NS;
	localparam int DET_EDGES = 2; // Crossings that prove the supply
	localparam int DLY_NS = 100_000; // Delay from supply ready to soft start
	localparam int DLY_CYC = (DLY_NS + CLK_NS - 1) / CLK_NS;
	localparam int SS_NS = 3_000_000; // Soft-start duration
	localparam int SS_CYC = SS_NS / CLK_NS;
	localparam int HIC_NS = 1_000_000; // Hiccup off interval
	localparam int HIC_CYC = (HIC_NS + CLK_NS - 1) / CLK_NS;
	localparam int SS_STEPS = 256; // Ramp steps of the target
	localparam logic [15:0] DET_LAST = 16'(DET_CYC - 1);
	localparam logic [15:0] DET_W = 16'(DET_W_CYC);
	localparam logic [15:0] DLY_LAST = 16'(DLY_CYC - 1);
	localparam logic [1:0] DET_EDGE_LAST = 2'(DET_EDGES - 1);
	localparam logic [7:0] SS_TOP = 8'hFF;
	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [5:0] {
		ST_DETECT = 6'h01,
		ST_DELAY = 6'h02,
		ST_SOFT = 6'h04,
		ST_RUN = 6'h08,
		ST_HICCUP = 6'h10,
		ST_LATCHED = 6'h20
	} bfps_state_t;
	// Comparator results from the analog front end
	typedef struct packed {
		logic sw_below_oc;
		logic sw_above_det;
		logic fdbk_low;
		logic over_temp;
	} bfps_pins_t;
endpackage : bfps_pkg

/* File: hw/bfps_top.sv */
// Fault-protection sequencer and gate-drive gating for a synchronous buck.
// Comparator inputs are asynchronous; the duty request comes from logic on CLK.
`timescale 1ns/1ps
module bfps_top
	import bfps_pkg::*;
#(
	parameter int SS_CYCLES = SS_CYC,
	parameter int HICCUP_CYCLES = HIC_CYC
) (
	// Clock and power-on reset
	input wire logic CLK,
	input wire logic RST_N,
	// Duty request from the modulator
	input wire logic [5:0] DUTY_REQ,
	// Analog comparator results
	input wire logic SW_NODE_BELOW_OC,
	input wire logic SW_NODE_ABOVE_DET,
	input wire logic FEEDBACK_LEVEL_LOW,
	input wire logic DIE_OVER_TEMP,
	// Gate drives
	output logic HIGH_SIDE_GATE_DRIVE,
	output logic LOW_SIDE_GATE_DRIVE,
	// Soft-start regulation target
	output logic [7:0] SOFT_START_TARGET,
	// Status
	output logic OVERCURRENT_SHUTDOWN,
	output logic UNDERVOLTAGE_FAULT,
	output logic THERMAL_FAULT,
	output logic LATCHED_OFF,
	output logic SUPPLY_PRESENT
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam logic [15:0] STEP_LAST = 16'(SS_CYCLES / SS_STEPS - 1); // Ramp step
	localparam logic [15:0] HIC_T_LAST = 16'(HICCUP_CYCLES - 1); // Off interval
	bfps_pins_t meta_ff; // First synchroniser stage
	bfps_pins_t sync_ff; // Second synchroniser stage
	bfps_state_t state_ff; // Sequencer state
	bfps_state_t nxt_state;
	logic [15:0] tmr_ff; // Per-state timer
	logic [5:0] per_ff; // Position in switching cycle
	logic [5:0] duty_ff; // Duty for this cycle
	logic [5:0] duty_src; // Clamped request
	logic [5:0] duty_eff; // Duty after soft-start limit
	logic skip_ff; // High pulse suppressed this cycle
	logic oc_hit_ff; // Overcurrent seen this cycle
	logic [2:0] oc_cnt_ff; // Consecutive overcurrent cycles
	logic [1:0] hic_ff; // Overcurrent restarts so far
	logic [7:0] uv_cnt_ff; // Feedback-low run length
	logic [7:0] ss_ff; // Soft-start target
	logic [1:0] det_cnt_ff; // Switch-node crossings seen
	logic det_prev_ff; // Last crossing comparator level
	logic hs_ff, ls_ff, ocs_ff, uvf_ff, thm_ff, lat_ff, sup_ff;
	logic sw_act; // Converter switching
	logic per_end; // Last clock of a switching cycle
	logic same; // No state change this clock
	logic det_fall; // Switch node fell below detect level
	logic oc_samp; // Overcurrent sample point
	logic oc_trip; // Overcurrent shutdown declared
	logic uv_trip; // Undervoltage fault recognised
	logic thm; // Over-temperature seen
	logic ss_step; // Soft-start ramp step
	logic hs_nxt, ls_nxt;
	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	// Two flops on every comparator result
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= '{SW_NODE_BELOW_OC, SW_NODE_ABOVE_DET, FEEDBACK_LEVEL_LOW, DIE_OVER_TEMP};
			sync_ff <= meta_ff;
		end
	end
	// ****************************************************************
	// Decode
	// ****************************************************************
	// Qualifiers shared by the sequencer and drives
	always_comb begin
		sw_act = (state_ff == ST_SOFT) || (state_ff == ST_RUN);
		per_end = (per_ff == PER_LAST);
		same = (nxt_state == state_ff);
		det_fall = det_prev_ff && !sync_ff.sw_above_det;
		oc_samp = sw_act && ls_ff && (per_ff == duty_ff + OC_SAMP_OFS);
		oc_trip = sw_act && per_end && oc_hit_ff && (oc_cnt_ff == OC_LAST);
		uv_trip = (state_ff == ST_RUN) && sync_ff.fdbk_low && (uv_cnt_ff == UV_LAST);
		thm = sync_ff.over_temp;
		ss_step = (state_ff == ST_SOFT) && (tmr_ff == STEP_LAST);
		duty_src = (DUTY_REQ > DUTY_MAX) ? DUTY_MAX : DUTY_REQ;
		// Soft start caps duty with the ramping target
		if ((state_ff == ST_SOFT) && (ss_ff[7:2] < duty_src)) begin
			duty_eff = ss_ff[7:2];
		end else begin
			duty_eff = duty_src;
		end
	end
	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// Next state; thermal first, then overcurrent, then the rest
	always_comb begin
		nxt_state = state_ff;
		if (thm) begin
			nxt_state = ST_LATCHED;
		end else if (oc_trip) begin
			// Latch after the last allowed restart
			nxt_state = (hic_ff == HIC_LAST) ? ST_LATCHED : ST_HICCUP;
		end else begin
			case (state_ff)
				ST_DETECT: begin
					if (det_fall && (det_cnt_ff == DET_EDGE_LAST)) begin
						nxt_state = ST_DELAY;
					end
				end
				ST_DELAY: begin
					if (tmr_ff == DLY_LAST) begin
						nxt_state = ST_SOFT;
					end
				end
				ST_SOFT: begin
					if (ss_step && (ss_ff == SS_TOP)) begin
						nxt_state = ST_RUN;
					end
				end
				ST_RUN: begin
					if (uv_trip) begin
						nxt_state = ST_HICCUP;
					end
				end
				ST_HICCUP: begin
					if (tmr_ff == HIC_T_LAST) begin
						nxt_state = ST_SOFT;
					end
				end
				ST_LATCHED: begin
					nxt_state = ST_LATCHED;
				end
				default: begin
					nxt_state = ST_DETECT;
				end
			endcase
		end
	end
	// State register
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_ff <= ST_DETECT;
		end else begin
			state_ff <= nxt_state;
		end
	end
	// State timer; restarts on every state change
	always_ff @(posedge CLK) begin
		if (!RST_N || !same) begin
			tmr_ff <= '0;
		end else if ((state_ff == ST_DETECT) && (tmr_ff == DET_LAST)) begin
			tmr_ff <= '0;
		end else if (ss_step) begin
			tmr_ff <= '0;
		end else if ((state_ff == ST_DELAY) || (state_ff == ST_HICCUP) ||
				(state_ff == ST_DETECT) || (state_ff == ST_SOFT)) begin
			tmr_ff <= tmr_ff + 16'h0001;
		end
	end
	// ****************************************************************
	// Supply detection
	// ****************************************************************
	// Count falling crossings while pulsing
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			det_prev_ff <= 1'b0;
			det_cnt_ff <= '0;
			sup_ff <= 1'b0;
		end else begin
			det_prev_ff <= sync_ff.sw_above_det;
			if (state_ff != ST_DETECT) begin
				det_cnt_ff <= '0;
			end else if (det_fall) begin
				det_cnt_ff <= det_cnt_ff + 2'h1;
			end
			if ((state_ff == ST_DETECT) && (nxt_state == ST_DELAY)) begin
				sup_ff <= 1'b1;
			end
		end
	end
	// ****************************************************************
	// Soft start
	// ****************************************************************
	// Target ramps from zero each time soft start is entered
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ss_ff <= '0;
		end else if ((nxt_state == ST_SOFT) && (state_ff != ST_SOFT)) begin
			ss_ff <= '0;
		end else if ((state_ff == ST_HICCUP) || (state_ff == ST_LATCHED)) begin
			ss_ff <= '0;
		end else if (ss_step && (ss_ff != SS_TOP)) begin
			ss_ff <= ss_ff + 8'h01;
		end
	end
	// ****************************************************************
	// Switching cycle and current limit
	// ****************************************************************
	// Cycle position and duty latched at each cycle start
	always_ff @(posedge CLK) begin
		if (!RST_N || !sw_act || !same) begin
			per_ff <= '0;
			duty_ff <= '0;
		end else if (per_end) begin
			per_ff <= '0;
			duty_ff <= duty_eff;
		end else begin
			per_ff <= per_ff + 6'h01;
		end
	end
	// Overcurrent sampling, pulse skipping and run count
	always_ff @(posedge CLK) begin
		if (!RST_N || !sw_act) begin
			oc_hit_ff <= 1'b0;
			skip_ff <= 1'b0;
			oc_cnt_ff <= '0;
		end else if (per_end) begin
			oc_hit_ff <= 1'b0;
			skip_ff <= oc_hit_ff;
			oc_cnt_ff <= oc_hit_ff ? oc_cnt_ff + 3'h1 : 3'h0;
		end else if (oc_samp && sync_ff.sw_below_oc) begin
			oc_hit_ff <= 1'b1;
		end
	end
	// Restart count; only power-on reset clears it
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			hic_ff <= '0;
		end else if (oc_trip && !thm && (hic_ff != HIC_LAST)) begin
			hic_ff <= hic_ff + 2'h1;
		end
	end
	// ****************************************************************
	// Undervoltage
	// ****************************************************************
	// Run length of low feedback, only while regulating
	always_ff @(posedge CLK) begin
		if (!RST_N || (state_ff != ST_RUN) || !sync_ff.fdbk_low) begin
			uv_cnt_ff <= '0;
		end else if (uv_cnt_ff != UV_LAST) begin
			uv_cnt_ff <= uv_cnt_ff + 8'h01;
		end
	end
	// ****************************************************************
	// Gate drives and status
	// ****************************************************************
	// Drives go low in any clock that changes state
	always_comb begin
		hs_nxt = 1'b0;
		ls_nxt = 1'b0;
		if (same && (state_ff == ST_DETECT)) begin
			hs_nxt = (tmr_ff < DET_W);
		end else if (same && sw_act) begin
			hs_nxt = !skip_ff && (per_ff < duty_ff);
			ls_nxt = (per_ff >= duty_ff + DEAD_T) && (per_ff < LS_END);
		end
	end
	// Registered drives and status outputs
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			hs_ff <= 1'b0;
			ls_ff <= 1'b0;
			ocs_ff <= 1'b0;
			uvf_ff <= 1'b0;
			thm_ff <= 1'b0;
			lat_ff <= 1'b0;
		end else begin
			hs_ff <= hs_nxt;
			ls_ff <= ls_nxt;
			ocs_ff <= oc_trip && !thm;
			uvf_ff <= uv_trip && !oc_trip && !thm;
			thm_ff <= thm_ff || thm;
			lat_ff <= (nxt_state == ST_LATCHED);
		end
	end
	assign HIGH_SIDE_GATE_DRIVE = hs_ff;
	assign LOW_SIDE_GATE_DRIVE = ls_ff;
	assign SOFT_START_TARGET = ss_ff;
	assign OVERCURRENT_SHUTDOWN = ocs_ff;
	assign UNDERVOLTAGE_FAULT = uvf_ff;
	assign THERMAL_FAULT = thm_ff;
	assign LATCHED_OFF = lat_ff;
	assign SUPPLY_PRESENT = sup_ff;
	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	sequence seq_oc_cycle;
		sw_act && per_end && oc_hit_ff && same;
	endsequence
	sequence seq_oc_last;
		oc_trip && !thm && (hic_ff == HIC_LAST);
	endsequence
	sequence seq_enter_hiccup;
		(state_ff != ST_HICCUP) ##1 (state_ff == ST_HICCUP);
	endsequence
	chk_oc_skip_high: assert property (seq_oc_cycle |=> skip_ff ##1 !hs_ff)
		else $error("high pulse not skipped after overcurrent");
	chk_low_keeps: assert property (sw_act && same && skip_ff &&
			(per_ff == duty_ff + DEAD_T) |=> ls_ff)
		else $error("low side stopped during skip");
	chk_oc_resume: assert property (sw_act && per_end && !oc_hit_ff && same
			|=> !skip_ff)
		else $error("high pulse not resumed");
	chk_oc_run_four: assert property (OVERCURRENT_SHUTDOWN |->
			$past(oc_cnt_ff) == OC_LAST && $past(oc_hit_ff))
		else $error("shutdown without four events");
	chk_hiccup_off: assert property (seq_enter_hiccup |->
			(!hs_ff && !ls_ff)[*8])
		else $error("drive active in hiccup");
	chk_oc_latch: assert property (seq_oc_last |=> state_ff == ST_LATCHED)
		else $error("no latch-off after last restart");
	chk_uv_gated: assert property (state_ff != ST_RUN |=> uv_cnt_ff == 8'h00)
		else $error("undervoltage watched outside regulation");
	chk_uv_delay: assert property (UNDERVOLTAGE_FAULT |->
			$past(uv_cnt_ff) == UV_LAST && $past(sync_ff.fdbk_low))
		else $error("undervoltage recognised early");
	chk_uv_restart: assert property (UNDERVOLTAGE_FAULT |->
			state_ff == ST_HICCUP && $stable(hic_ff))
		else $error("undervoltage did not hiccup");
	chk_thermal_latch: assert property (thm |=> state_ff == ST_LATCHED ##1
			(state_ff == ST_LATCHED && THERMAL_FAULT && !hs_ff && !ls_ff))
		else $error("thermal fault not latched");
	chk_ss_from_zero: assert property ($rose(state_ff == ST_SOFT) |->
			ss_ff == 8'h00)
		else $error("soft start not from zero");
	chk_detect_done: assert property (state_ff == ST_DETECT && nxt_state == ST_DELAY
			&& !thm |-> det_cnt_ff == DET_EDGE_LAST && det_fall)
		else $error("supply accepted early");
	chk_hiccup_exit: assert property (state_ff == ST_HICCUP && nxt_state != ST_HICCUP
			&& !thm |-> tmr_ff == HIC_T_LAST && nxt_state == ST_SOFT)
		else $error("hiccup interval wrong");
	chk_latch_hold: assert property (state_ff == ST_LATCHED |=>
			state_ff == ST_LATCHED && LATCHED_OFF)
		else $error("latch-off released");
endmodule : bfps_top

/* File: test/bfps_stage_model.sv */
// Behavioural power stage, divider and die sensor facing the sequencer.
// Assumes the bench commands supply, overload, feedback dips and heat.
`timescale 1ns/1ps
module bfps_stage_model
	import bfps_pkg::*;
(
	// Clock and gate drives from the sequencer
	input wire logic clk,
	input wire logic hs_on,
	input wire logic ls_on,
	// Bench commands
	input wire logic vin_on,
	input wire logic oc_go,
	input wire logic [2:0] oc_num,
	input wire logic fb_drop,
	input wire logic hot,
	// Comparator results towards the sequencer
	output bfps_pins_t pins
);
	// ****************************************************************
	// Overload and sensing
	// ****************************************************************
	logic [2:0] pend_ff; // Overloaded low-side periods still to come
	logic ls_prev_ff; // Low drive at the previous falling edge
	initial begin
		pins = '0;
		pend_ff = 3'h0;
		ls_prev_ff = 1'b0;
	end
	// Overload lasts whole switching periods, one used up per low-side turn-off
	always @(negedge clk) begin
		ls_prev_ff <= ls_on;
		if (oc_go) begin
			pend_ff <= oc_num;
		end else if (ls_prev_ff && !ls_on && pend_ff != 3'h0) begin
			pend_ff <= pend_ff - 3'h1;
		end
	end
	// Comparators change off the sampling edge; the phase swings only with supply
	always @(negedge clk) begin
		pins.sw_above_det <= vin_on & hs_on;
		pins.sw_below_oc <= (pend_ff != 3'h0);
		pins.fdbk_low <= fb_drop;
		pins.over_temp <= hot;
	end
endmodule : bfps_stage_model

/* File: test/tb_buck_fault_protection_sequencer.sv */
// Self-checking bench for the buck fault-protection sequencer.
// Assumes bfps_pkg, bfps_top and bfps_stage_model are compiled before it.
`timescale 1ns/1ps
module tb_buck_fault_protection_sequencer
	import bfps_pkg::*;
;
	// ****************************************************************
	// Signals
	// ****************************************************************
	localparam int SS_N = 512; // Short soft start, two clocks a step
	localparam int HIC_N = 16; // Short hiccup off interval
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [5:0] DUTY_REQ = 6'h14;
	bfps_pins_t pins; // Comparator results from the stage
	logic hs, ls, ocs, uvf, thf, lat, sup; // Design outputs
	logic [7:0] tgt; // Soft-start target
	logic vin_on = 1'b0, oc_go = 1'b0, fb_drop = 1'b0, hot = 1'b0; // Stage commands
	logic [2:0] oc_num = 3'h0; // Overloaded periods to request
	logic [7:0] lfsr = 8'h5C; // Random source, fixed seed
	int fail_count = 0;
	int n_checks = 0;
	int n_oc = 0, n_uv = 0; // Status pulses seen
	always #(CLK_NS / 2) CLK = ~CLK;
	bfps_top #(.SS_CYCLES(SS_N), .HICCUP_CYCLES(HIC_N)) bfps_top_inst (
		.CLK(CLK), .RST_N(RST_N), .DUTY_REQ(DUTY_REQ),
		.SW_NODE_BELOW_OC(pins.sw_below_oc), .SW_NODE_ABOVE_DET(pins.sw_above_det),
		.FEEDBACK_LEVEL_LOW(pins.fdbk_low), .DIE_OVER_TEMP(pins.over_temp),
		.HIGH_SIDE_GATE_DRIVE(hs), .LOW_SIDE_GATE_DRIVE(ls), .SOFT_START_TARGET(tgt),
		.OVERCURRENT_SHUTDOWN(ocs), .UNDERVOLTAGE_FAULT(uvf), .THERMAL_FAULT(thf),
		.LATCHED_OFF(lat), .SUPPLY_PRESENT(sup));
	bfps_stage_model bfps_stage_model_inst (.clk(CLK), .hs_on(hs), .ls_on(ls),
		.vin_on(vin_on), .oc_go(oc_go), .oc_num(oc_num), .fb_drop(fb_drop), .hot(hot),
		.pins(pins));
	// Pulse counters
	always @(negedge CLK) begin
		if (ocs === 1'b1) n_oc++;
		if (uvf === 1'b1) n_uv++;
	end
	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsr_next
	// High-side pulses left in a window after a run of overload events
	function automatic int exp_hi(input int n, input int per);
		return per - ((n < per) ? n : per - 1);
	endfunction : exp_hi
	function automatic logic sig(input int s);
		case (s)
			0: return ocs;
			1: return uvf;
			2: return thf;
			3: return sup;
			default: return tgt == 8'hFF;
		endcase
	endfunction : sig
	task automatic chk_bit(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: %s got %b exp %b", $time, what, got, exp);
		end
	endtask : chk_bit
	task automatic chk_num(input int got, input int lo, input int hi, input string what);
		n_checks++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("mismatch at %0t: %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
		end
	endtask : chk_num
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done
	// Bounded wait for a status; gives lim+1 on timeout
	task automatic wait_for(input int s, input int lim, output int cyc);
		cyc = 0;
		while (sig(s) !== 1'b1 && cyc <= lim) begin
			@(negedge CLK);
			cyc++;
		end
	endtask : wait_for
	// Counts drive rises over n low-side turn-offs
	task automatic count_per(input int n, output int nh, output int nl);
		logic ph, pl;
		int k, t;
		nh = 0;
		nl = 0;
		k = 0;
		t = 0;
		ph = hs;
		pl = ls;
		while (k < n && t < 60 * n) begin
			@(negedge CLK);
			t++;
			if (hs && !ph) nh++;
			if (ls && !pl) nl++;
			if (!ls && pl) k++;
			ph = hs;
			pl = ls;
		end
	endtask : count_per
	// Overload for the next n periods, aligned to a low-side turn-off
	// A state change just ahead forces a turn-off and clears the duty, so let it pass
	task automatic oc_load(input logic [2:0] n);
		int a, b;
		repeat (4) @(negedge CLK);
		count_per(1, a, b);
		oc_num <= n;
		oc_go <= 1'b1;
		@(negedge CLK);
		oc_go <= 1'b0;
	endtask : oc_load
	// Watches drives for n clocks; any is set if either drive was on
	task automatic hold_off(input int n, output logic any);
		any = 1'b0;
		repeat (n) begin
			@(negedge CLK);
			any = any | hs | ls;
		end
	endtask : hold_off
	// Off interval then the wait until the ramp tops out
	task automatic rerun(output logic any, output int cyc);
		hold_off(HIC_N - 2, any);
		wait_for(4, SS_N + 100, cyc);
		cyc = cyc + HIC_N - 2;
	endtask : rerun
	task automatic new_duty;
		lfsr = lfsr_next(lfsr);
		DUTY_REQ <= 6'(8 + lfsr % 30);
	endtask : new_duty
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		int nh, nl, cyc;
		int evs[3] = '{1, 2, 3};
		logic any;
		repeat (20) @(negedge CLK);
		chk_bit(hs | ls | lat | sup | thf, 1'b0, "outputs idle in reset");
		RST_N <= 1'b1;
		// No input supply: detection pulses continue
		nh = 0;
		any = 1'b0;
		repeat (8000) begin
			@(negedge CLK);
			if (hs && !any) nh++;
			any = hs;
		end
		chk_num(nh, 2, 3, "detect pulses");
		chk_bit(sup, 1'b0, "supply absent");
		vin_on <= 1'b1;
		wait_for(3, 7000, cyc);
		chk_num(cyc, 1, 7000, "supply found");
		chk_bit(tgt == 8'h00, 1'b1, "ramp starts at zero");
		wait_for(4, 3000, cyc);
		chk_num(cyc, 2000 + SS_N - 8, 2000 + SS_N + 60, "soft start time");
		// Short feedback dip, then a lasting one with endless restarts
		new_duty();
		lfsr = lfsr_next(lfsr);
		cyc = 100 + int'(lfsr % 90);
		fb_drop <= 1'b1;
		repeat (cyc) @(negedge CLK);
		fb_drop <= 1'b0;
		repeat (20) @(negedge CLK);
		chk_num(n_uv, 0, 0, "dip filtered");
		fb_drop <= 1'b1;
		wait_for(1, 400, cyc);
		chk_num(cyc, UV_CYC, UV_CYC + 6, "undervoltage delay");
		repeat (4) begin
			hold_off(HIC_N - 2, any);
			chk_bit(any, 1'b0, "drives off in hiccup");
			wait_for(1, SS_N + UV_CYC + 200, cyc);
			cyc = cyc + HIC_N - 2;
			chk_num(cyc, HIC_N + SS_N, HIC_N + SS_N + UV_CYC + 30, "restart gap");
		end
		chk_bit(lat, 1'b0, "no latch on undervoltage");
		fb_drop <= 1'b0;
		rerun(any, cyc);
		// Short overload runs skip high-side pulses only
		foreach (evs[i]) begin
			new_duty();
			oc_load(3'(evs[i]));
			count_per(4, nh, nl);
			chk_num(nh, exp_hi(evs[i], 4), exp_hi(evs[i], 4), "high pulses");
			chk_num(nl, 4, 4, "low pulses");
		end
		chk_num(n_oc, 0, 0, "no shutdown under four");
		// Four-event runs: three restarts, then latch-off
		for (int i = 0; i < 4; i++) begin
			new_duty();
			oc_load(3'h4);
			wait_for(0, 300, cyc);
			chk_num(cyc, 150, 260, "four events to shutdown");
			rerun(any, cyc);
			chk_bit(any, 1'b0, "drives off after shutdown");
			chk_bit(lat, i == 3, "latch after three restarts");
			if (i < 3) chk_num(cyc, HIC_N + SS_N - 8, HIC_N + SS_N + 60, "hiccup rerun");
		end
		hold_off(300, any);
		chk_bit(any | ~lat, 1'b0, "latched drives off");
		RST_N <= 1'b0;
		repeat (3) @(negedge CLK);
		RST_N <= 1'b1;
		@(negedge CLK);
		chk_bit(lat, 1'b0, "reset clears latch");
		wait_for(3, 7000, cyc);
		wait_for(4, 3000, cyc);
		oc_load(3'h4);
		wait_for(0, 300, cyc);
		rerun(any, cyc);
		chk_bit(lat | any, 1'b0, "restart count cleared");
		// Over-temperature latches past cooling
		hot <= 1'b1;
		wait_for(2, 20, cyc);
		hot <= 1'b0;
		chk_num(cyc, 2, 6, "thermal latency");
		hold_off(300, any);
		chk_bit(any | ~lat, 1'b0, "thermal drives off");
		chk_bit(thf, 1'b1, "thermal fault persists");
		RST_N <= 1'b0;
		repeat (3) @(negedge CLK);
		chk_bit(thf | lat, 1'b0, "reset clears thermal");
		test_done();
	end
	// Watchdog over the expected run length
	initial begin
		repeat (60000) @(posedge CLK);
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		test_done();
	end
endmodule : tb_buck_fault_protection_sequencer
